// ===== dv/cg_clock_generator_tb_top.sv
// Self-checking bench for the clock generator control block
`timescale 1ns/100ps
`include "cg_clock_map.svh"
module cg_clock_generator_tb_top;
	import cg_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk;
	logic        rst;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic        wp;
	logic [7:0]  cyc = 8'h00;
	logic [2:0]  mc = 3'h0;
	logic        rcs;
	logic [2:0]  rcf;
	logic        rcen;
	logic        xten;
	logic        xtok;
	logic        sel;
	logic        cfd;
	logic        mon;
	logic [7:0]  div;
	logic [10:0] mul;
	logic        pen;
	logic        lock;
	cg_src_t     src;
	logic        tick;
	int          errors;
	int          n_tests;
	int          p;
	logic [31:0] d;
	logic [31:0] d2;

	cg_clock_generator dut
	(
		.i_core_clk                 (clk),
		.i_rst                      (rst),
		.i_addr                     (addr),
		.i_wdata                    (wdata),
		.i_wr                       (wr),
		.i_rd                       (rd),
		.o_rdata                    (rdata),
		.i_write_protect_enable     (wp),
		.i_rc_stable_flag           (rcs),
		.i_slow_clk                 (cyc[3]),
		.i_main_clk                 (mc < 3'h3),
		.i_pll_clk                  (cyc[2]),
		.o_rc_freq_select           (rcf),
		.o_rc_osc_enable            (rcen),
		.o_xtal_enable              (xten),
		.o_xtal_stable              (xtok),
		.o_main_osc_select          (sel),
		.o_fail_detect_enable       (cfd),
		.o_slow_xtal_monitor_enable (mon),
		.o_pll_input_divider        (div),
		.o_pll_multiplier           (mul),
		.o_pll_enable               (pen),
		.o_pll_locked_flag          (lock),
		.o_master_source_select     (src),
		.o_master_clock_tick        (tick)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Pin clocks: slow 16, main 6, PLL 8 core cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 8'h01;
		mc  <= (mc == 3'h5) ? 3'h0 : mc + 3'h1;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wreg(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [31:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic cwait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Cycles between two master ticks
	task automatic gap(output int g);
		int k;
		k = 0;
		while (tick !== 1'b1 && k < 3000)
		begin
			cwait(1);
			k++;
		end
		cwait(1);
		g = 1;
		while (tick !== 1'b1 && g < 3000)
		begin
			cwait(1);
			g++;
		end
	endtask
	task automatic mgap(input logic [31:0] v, input int exp);
		wreg(`CG_ADDR_MCKR, v);
		gap(p);
		gap(p);
		check(32'(p), 32'(exp));
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		check(32'({rcf, rcen, xten, lock, src}), 32'h51);
		rreg(`CG_ADDR_PLLR, d);
		check(d, 32'h2000_0000);
		rreg(`CG_ADDR_MCKR, d);
		check(d, 32'h0000_0001);
		rreg(32'h400E_0500, d);
		check(d, 32'h0);
		@(posedge clk);
		rcs <= 1'b0;
		rreg(`CG_ADDR_SR, d);
		check(d, 32'h0000_0008);
		@(posedge clk);
		rcs <= 1'b1;
		$display("test reset done");
	endtask
	task automatic t_rcfreq;
		for (int f = 0; f < 3; f++)
		begin
			wreg(`CG_ADDR_MOR, 32'h0037_0008 | 32'(f << 4));
			check(32'(rcf), 32'(f));
		end
		@(posedge clk);
		wp <= 1'b1;
		wreg(`CG_ADDR_MOR, 32'h0037_0008);
		check(32'(rcf), 32'h2);
		@(posedge clk);
		wp <= 1'b0;
		wreg(`CG_ADDR_MOR, 32'h0036_0008);
		check(32'(rcf), 32'h2);
		$display("test rc frequency done");
	endtask
	task automatic t_osc;
		wreg(`CG_ADDR_MOR, 32'h0637_0229);
		check(32'({sel, cfd, mon, rcf}), 32'h1A);
		cwait(32);
		rreg(`CG_ADDR_SR, d);
		check(d, 32'h0002_0008);
		wreg(`CG_ADDR_MOR, 32'h0537_0229);
		check(32'({sel, cfd, mon}), 32'h5);
		wreg(`CG_ADDR_MOR, 32'h0037_0229);
		check(32'({sel, cfd, mon}), 32'h0);
		cwait(190);
		check(32'(xtok), 32'h0);
		cwait(130);
		check(32'(xtok), 32'h1);
		$display("test oscillator done");
	endtask
	task automatic t_meter;
		for (int s = 0; s < 2; s++)
		begin
			wreg(`CG_ADDR_MOR, 32'h0037_0229 | 32'(s << 24));
			wreg(`CG_ADDR_MCFR, 32'h0010_0000);
			rreg(`CG_ADDR_MCFR, d);
			check(32'(d[16]), 32'h0);
			cwait(320);
			rreg(`CG_ADDR_MCFR, d);
			rreg(`CG_ADDR_MCFR, d2);
			check(32'({d[16], d[15:0] > 16'h0029 && d[15:0] < 16'h002C}), 32'h3);
			check(d2, d);
		end
		wreg(`CG_ADDR_MOR, 32'h0037_0021);
		rreg(`CG_ADDR_MCFR, d);
		check(32'(d[16]), 32'h0);
		wreg(`CG_ADDR_MOR, 32'h0037_0229);
		$display("test meter done");
	endtask
	task automatic t_pll;
		wreg(`CG_ADDR_PLLR, 32'h2004_0301);
		check(32'({pen, lock, div, mul}), 32'({2'b00, 8'h01, 11'h004}));
		cwait(1);
		check(32'(pen), 32'h1);
		cwait(30);
		check(32'(lock), 32'h0);
		cwait(50);
		check(32'(lock), 32'h1);
		rreg(`CG_ADDR_SR, d);
		check(d, 32'h0002_000B);
		wreg(`CG_ADDR_PLLR, 32'h2004_0300);
		cwait(1);
		check(32'({pen, lock}), 32'h0);
		wreg(`CG_ADDR_PLLR, 32'h2000_0301);
		cwait(1);
		check(32'({pen, lock}), 32'h0);
		wreg(`CG_ADDR_PLLR, 32'h2004_0301);
		cwait(80);
		$display("test pll done");
	endtask
	task automatic t_master;
		int k;
		for (int i = 0; i < 8; i++)
			mgap(32'h1 | 32'(i << 4), (i == 7) ? 18 : 6 << i);
		rreg(`CG_ADDR_MCKR, d);
		check(d, 32'h0000_0071);
		mgap(32'h0, 16);
		mgap(32'h2, 8);
		check(32'(src), 32'(CG_SRC_PLL));
		mgap(32'h1002, 16);
		wreg(`CG_ADDR_MCKR, 32'h3);
		k = 0;
		repeat (300)
		begin
			cwait(1);
			if (tick === 1'b1)
				k++;
		end
		check(32'(k), 32'h0);
		$display("test master clock done");
	endtask
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial
	begin
		rst     = 1'b1;
		addr    = 32'h0;
		wdata   = 32'h0;
		wr      = 1'b0;
		rd      = 1'b0;
		wp      = 1'b0;
		rcs     = 1'b1;
		errors  = 0;
		n_tests = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		cwait(1);
		t_reset;
		t_rcfreq;
		t_osc;
		t_meter;
		t_pll;
		t_master;
		report_and_stop;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		report_and_stop;
	end
endmodule

// ===== logic/cg_clock_generator.sv
// Clock generator control: oscillator, frequency meter, PLL and master clock logic
//
// Overview of operation
// - RC frequency field picks 12, 8, 4 MHz
// - RC oscillator starts at 4 MHz
// - Crystal start-up is count times 8 slow
// - Select bit picks RC or crystal main
// - Failure detector runs only while enabled
// - Slow crystal monitor runs only while enabled
// - Count main cycles within 16 slow periods
// - Valid flag low until a good count
// - Writing restart bit restarts the measurement
// - Meter counts whichever source drives main
// - Writes ignored while write protect set
// - Divider zero disables, one bypasses, else divides
// - Lock flag after programmed slow cycle count
// - Multiplier zero disables, else multiplies by M+1
// - Source field picks slow, main, PLL
// - Prescaler divides by powers of two or three
// - Halve bit divides PLL clock by two
`timescale 1ns/100ps
`include "cg_clock_map.svh"
module cg_clock_generator
(
	// Clock and reset
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	// Register port
	input  wire logic [31:0]          i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [31:0]          o_rdata,
	// Status from surrounding logic
	input  wire logic                 i_write_protect_enable,
	input  wire logic                 i_rc_stable_flag,
	// Clock pins sampled as inputs
	input  wire logic                 i_slow_clk,
	input  wire logic                 i_main_clk,
	input  wire logic                 i_pll_clk,
	// Oscillator controls
	output logic      [2:0]           o_rc_freq_select,
	output logic                      o_rc_osc_enable,
	output logic                      o_xtal_enable,
	output logic                      o_xtal_stable,
	output logic                      o_main_osc_select,
	output logic                      o_fail_detect_enable,
	output logic                      o_slow_xtal_monitor_enable,
	// PLL controls
	output logic      [7:0]           o_pll_input_divider,
	output logic      [10:0]          o_pll_multiplier,
	output logic                      o_pll_enable,
	output logic                      o_pll_locked_flag,
	// Master clock
	output cg_pkg::cg_src_t           o_master_source_select,
	output logic                      o_master_clock_tick
);
	import cg_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [`CG_SYNC_CH-1:0] pin_in;
	logic [`CG_SYNC_CH-1:0] tick;
	assign pin_in = {i_pll_clk, i_main_clk, i_slow_clk};

	genvar g;
	generate
		for (g = 0; g < `CG_SYNC_CH; g++)
		begin : g_sync
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			logic lvl_nxt;
			assign lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
			assign tick[g] = lvl_nxt & ~lvl_r;
			always_ff @(posedge i_core_clk)
			begin
				if (i_rst)
				begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					s3_r  <= 1'b0;
					lvl_r <= 1'b0;
				end
				else
				begin
					s1_r  <= pin_in[g];
					s2_r  <= s1_r;
					s3_r  <= s2_r;
					lvl_r <= lvl_nxt;
				end
			end
		end
	endgenerate

	logic slow_tick;
	logic main_tick;
	logic pll_tick;
	assign slow_tick = tick[`CG_CH_SLOW];
	assign main_tick = tick[`CG_CH_MAIN];
	assign pll_tick  = tick[`CG_CH_PLL];

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	logic wr_ok;
	logic wr_mor;
	logic wr_mcfr;
	logic wr_pll;
	logic wr_mck;
	assign wr_ok   = i_wr & ~i_write_protect_enable;
	assign wr_mor  = wr_ok & (i_addr == `CG_ADDR_MOR)
		& (i_wdata[`CG_MOR_KEY_MSB:`CG_MOR_KEY_LSB] == `CG_MOR_KEY);
	assign wr_mcfr = wr_ok & (i_addr == `CG_ADDR_MCFR);
	assign wr_pll  = wr_ok & (i_addr == `CG_ADDR_PLLR);
	assign wr_mck  = wr_ok & (i_addr == `CG_ADDR_MCKR);

	logic       restart_req;
	assign restart_req = wr_mcfr & i_wdata[`CG_MCFR_MEAS];

	// ----------------------------------------
	// Main oscillator register
	// ----------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_rc_freq_select           <= `CG_RCF_4MHZ;
			o_rc_osc_enable            <= 1'b1;
			o_xtal_enable              <= 1'b0;
			o_main_osc_select          <= 1'b0;
			o_fail_detect_enable       <= 1'b0;
			o_slow_xtal_monitor_enable <= 1'b0;
		end
		else if (wr_mor)
		begin
			o_rc_freq_select           <= i_wdata[`CG_MOR_RCF_MSB:`CG_MOR_RCF_LSB];
			o_rc_osc_enable            <= i_wdata[`CG_MOR_RCEN];
			o_xtal_enable              <= i_wdata[`CG_MOR_XTEN];
			o_main_osc_select          <= i_wdata[`CG_MOR_SEL];
			o_fail_detect_enable       <= i_wdata[`CG_MOR_FAIL_DETECT_ENABLE];
			o_slow_xtal_monitor_enable <= i_wdata[`CG_MOR_XTFME];
		end
	end

	logic [7:0] xtal_startup_count_r;
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			xtal_startup_count_r <= 8'h00;
		else if (wr_mor)
			xtal_startup_count_r <= i_wdata[`CG_MOR_XST_MSB:`CG_MOR_XST_LSB];
	end

	// ----------------------------------------
	// Crystal start-up timer
	// ----------------------------------------
	logic [10:0] xst_cnt_r;
	logic [10:0] xst_limit;
	logic        xst_done;
	assign xst_limit = {xtal_startup_count_r, 3'h0};
	assign xst_done  = (xst_cnt_r >= xst_limit);
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || !o_xtal_enable)
		begin
			xst_cnt_r     <= 11'h000;
			o_xtal_stable <= 1'b0;
		end
		else if (xst_done)
			o_xtal_stable <= 1'b1;
		else if (slow_tick)
			xst_cnt_r <= xst_cnt_r + 11'h001;
	end

	// ----------------------------------------
	// Main clock frequency meter
	// ----------------------------------------
	cg_meas_t    meas_r;
	cg_meas_t    meas_nxt;
	logic [15:0] main_freq_count_r;
	logic [15:0] run_cnt_r;
	logic [4:0]  per_cnt_r;
	logic        main_on;
	logic        freq_valid_flag;
	logic        window_end;
	assign main_on    = o_main_osc_select ? o_xtal_stable : o_rc_osc_enable;
	// Window opens on a slow edge, so it spans whole slow periods
	logic in_window;
	assign in_window  = (per_cnt_r != 5'h00);
	assign window_end = slow_tick & (per_cnt_r == `CG_MEAS_PERIODS);
	assign freq_valid_flag = (meas_r == CG_MEAS_DONE);

	always_comb
	begin
		meas_nxt = meas_r;
		if (!main_on)
			meas_nxt = CG_MEAS_IDLE;
		else if (restart_req)
			meas_nxt = CG_MEAS_RUN;
		else
		begin
			case (meas_r)
				CG_MEAS_IDLE: meas_nxt = CG_MEAS_RUN;
				CG_MEAS_RUN:  meas_nxt = window_end ? CG_MEAS_DONE : CG_MEAS_RUN;
				CG_MEAS_DONE: meas_nxt = CG_MEAS_DONE;
				default:      meas_nxt = CG_MEAS_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			meas_r            <= CG_MEAS_IDLE;
			main_freq_count_r <= 16'h0000;
			run_cnt_r         <= 16'h0000;
			per_cnt_r         <= 5'h00;
		end
		else
		begin
			meas_r <= meas_nxt;
			if (restart_req || (meas_nxt == CG_MEAS_RUN && meas_r != CG_MEAS_RUN))
			begin
				run_cnt_r <= 16'h0000;
				per_cnt_r <= 5'h00;
			end
			else if (meas_r == CG_MEAS_RUN)
			begin
				run_cnt_r <= run_cnt_r + {15'h0000, main_tick & in_window};
				per_cnt_r <= per_cnt_r + {4'h0, slow_tick};
			end
			if (meas_r == CG_MEAS_RUN && meas_nxt == CG_MEAS_DONE)
				main_freq_count_r <= run_cnt_r + {15'h0000, main_tick};
		end
	end

	// ----------------------------------------
	// PLL register and lock counter
	// ----------------------------------------
	logic [5:0] pll_lock_delay_r;
	logic [5:0] lock_cnt_r;
	logic       pll_on;
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_pll_input_divider <= 8'h00;
			o_pll_multiplier    <= 11'h000;
			pll_lock_delay_r    <= 6'h00;
		end
		else if (wr_pll)
		begin
			o_pll_input_divider <= i_wdata[`CG_PLL_DIV_MSB:`CG_PLL_DIV_LSB];
			o_pll_multiplier    <= i_wdata[`CG_PLL_MUL_MSB:`CG_PLL_MUL_LSB];
			pll_lock_delay_r    <= i_wdata[`CG_PLL_CNT_MSB:`CG_PLL_CNT_LSB];
		end
	end

	assign pll_on = (o_pll_input_divider != 8'h00) & (o_pll_multiplier != 11'h000);

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || wr_pll || !pll_on)
		begin
			lock_cnt_r        <= 6'h00;
			o_pll_locked_flag <= 1'b0;
			o_pll_enable      <= 1'b0;
		end
		else
		begin
			o_pll_enable <= 1'b1;
			if (lock_cnt_r >= pll_lock_delay_r)
				o_pll_locked_flag <= 1'b1;
			else if (slow_tick)
				lock_cnt_r <= lock_cnt_r + 6'h01;
		end
	end

	// ----------------------------------------
	// Master clock selection and prescaler
	// ----------------------------------------
	logic [2:0] master_prescaler_r;
	logic       pll_output_halve_r;
	logic       half_r;
	logic       pll_src_tick;
	logic       src_tick;
	logic [6:0] master_prescaler_cnt_r;
	logic [6:0] master_prescaler_last;
	logic       master_prescaler_wrap;

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_master_source_select <= CG_SRC_MAIN;
			master_prescaler_r     <= 3'h0;
			pll_output_halve_r     <= 1'b0;
		end
		else if (wr_mck)
		begin
			o_master_source_select <= cg_src_t'(i_wdata[`CG_MCK_CSS_MSB:`CG_MCK_CSS_LSB]);
			master_prescaler_r     <= i_wdata[`CG_MCK_MASTER_PRESCALER_MSB:`CG_MCK_MASTER_PRESCALER_LSB];
			pll_output_halve_r     <= i_wdata[`CG_MCK_DIV2];
		end
	end

	assign pll_src_tick = pll_tick & o_pll_locked_flag & (~pll_output_halve_r | half_r);
	assign src_tick = (o_master_source_select == CG_SRC_SLOW) ? slow_tick
		: (o_master_source_select == CG_SRC_MAIN) ? main_tick
		: (o_master_source_select == CG_SRC_PLL)  ? pll_src_tick : 1'b0;
	assign master_prescaler_last = (master_prescaler_r == `CG_MASTER_PRESCALER_DIV3) ? `CG_DIV3_LAST
		: 7'((7'h01 << master_prescaler_r) - 7'h01);
	assign master_prescaler_wrap = (master_prescaler_cnt_r >= master_prescaler_last);

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			half_r              <= 1'b0;
			master_prescaler_cnt_r          <= 7'h00;
			o_master_clock_tick <= 1'b0;
		end
		else
		begin
			if (pll_tick)
				half_r <= ~half_r;
			o_master_clock_tick <= src_tick & master_prescaler_wrap;
			if (src_tick)
				master_prescaler_cnt_r <= master_prescaler_wrap ? 7'h00 : master_prescaler_cnt_r + 7'h01;
		end
	end

	// ----------------------------------------
	// Read back
	// ----------------------------------------
	logic [31:0] rd_mor;
	logic [31:0] rd_mcfr;
	logic [31:0] rd_pll;
	logic [31:0] rd_mck;
	logic [31:0] rd_sr;
	logic [31:0] rd_mux;
	assign rd_mor = (32'(o_slow_xtal_monitor_enable) << `CG_MOR_XTFME)
		| (32'(o_fail_detect_enable) << `CG_MOR_FAIL_DETECT_ENABLE) | (32'(o_main_osc_select) << `CG_MOR_SEL)
		| (32'(xtal_startup_count_r) << `CG_MOR_XST_LSB)
		| (32'(o_rc_freq_select) << `CG_MOR_RCF_LSB)
		| (32'(o_rc_osc_enable) << `CG_MOR_RCEN) | (32'(o_xtal_enable) << `CG_MOR_XTEN);
	assign rd_mcfr = (32'(freq_valid_flag) << `CG_MCFR_RDY) | 32'(main_freq_count_r);
	assign rd_pll = (32'(o_pll_multiplier) << `CG_PLL_MUL_LSB) | (32'h1 << `CG_PLL_ONE)
		| (32'(pll_lock_delay_r) << `CG_PLL_CNT_LSB) | 32'(o_pll_input_divider);
	assign rd_mck = (32'(pll_output_halve_r) << `CG_MCK_DIV2)
		| (32'(master_prescaler_r) << `CG_MCK_MASTER_PRESCALER_LSB) | 32'(o_master_source_select);
	assign rd_sr = (32'(i_rc_stable_flag) << `CG_SR_RCS) | (32'h1 << `CG_SR_MCKRDY)
		| (32'(o_pll_locked_flag) << `CG_SR_LOCK) | (32'(o_xtal_stable) << `CG_SR_XTS);
	assign rd_mux = (i_addr == `CG_ADDR_MOR)  ? rd_mor
		: (i_addr == `CG_ADDR_MCFR) ? rd_mcfr
		: (i_addr == `CG_ADDR_PLLR) ? rd_pll
		: (i_addr == `CG_ADDR_MCKR) ? rd_mck
		: (i_addr == `CG_ADDR_SR)   ? rd_sr : 32'h00000000;

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			o_rdata <= 32'h00000000;
		else
			o_rdata <= i_rd ? rd_mux : 32'h00000000;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_pll_write;
		wr_pll;
	endsequence
	sequence s_pll_unlocked;
		!o_pll_locked_flag;
	endsequence

	chk_protect_blocks_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr && i_write_protect_enable) |=> $stable(o_pll_multiplier) && $stable(o_rc_freq_select))
		else $error("protected write changed a register");
	chk_rc_reset_freq: assert property (@(posedge i_core_clk)
		$fell(i_rst) |-> o_rc_freq_select == `CG_RCF_4MHZ)
		else $error("rc frequency not 4 MHz after reset");
	chk_pll_lock_restart: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_pll_write |=> s_pll_unlocked)
		else $error("pll lock not cleared by write");
	chk_pll_off_unlocked: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(o_pll_input_divider == 8'h00) |=> !o_pll_locked_flag && !o_pll_enable)
		else $error("pll locked with divider zero");
	chk_mul_zero_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(o_pll_multiplier == 11'h000) |=> !o_pll_enable)
		else $error("pll enabled with multiplier zero");
	chk_restart_clears_valid: assert property (@(posedge i_core_clk) disable iff (i_rst)
		restart_req |=> !freq_valid_flag)
		else $error("restart left valid flag high");
	chk_valid_needs_main: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!main_on |=> !freq_valid_flag)
		else $error("valid flag with main oscillator off");
	chk_xtal_not_early: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_xtal_stable) |-> xst_cnt_r == xst_limit)
		else $error("crystal stable before start-up time");
	chk_meter_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(meas_r == CG_MEAS_RUN && meas_nxt == CG_MEAS_DONE)
		|=> main_freq_count_r == $past(run_cnt_r) + 16'($past(main_tick)))
		else $error("meter count not loaded at window end");
	chk_master_tick_src: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_master_clock_tick |-> $past(src_tick))
		else $error("master tick without source tick");
endmodule

// ===== logic/cg_clock_map.svh
// Register map, field positions, field encodings and counts of the clock generator
`ifndef CG_CLOCK_MAP_SVH
`define CG_CLOCK_MAP_SVH
`define CG_ADDR_MOR          32'h400E0420
`define CG_ADDR_MCFR         32'h400E0424
`define CG_ADDR_PLLR         32'h400E0428
`define CG_ADDR_MCKR         32'h400E0430
`define CG_ADDR_SR           32'h400E0468
`define CG_MOR_XTEN          0
`define CG_MOR_RCEN          3
`define CG_MOR_RCF_LSB       4
`define CG_MOR_RCF_MSB       6
`define CG_MOR_XST_LSB       8
`define CG_MOR_XST_MSB       15
`define CG_MOR_KEY_LSB       16
`define CG_MOR_KEY_MSB       23
`define CG_MOR_SEL           24
`define CG_MOR_FAIL_DETECT_ENABLE         25
`define CG_MOR_XTFME         26
`define CG_MOR_KEY           8'h37
`define CG_RCF_12MHZ         3'h0
`define CG_RCF_8MHZ          3'h1
`define CG_RCF_4MHZ          3'h2
`define CG_MCFR_CNT_MSB      15
`define CG_MCFR_RDY          16
`define CG_MCFR_MEAS         20
`define CG_PLL_DIV_LSB       0
`define CG_PLL_DIV_MSB       7
`define CG_PLL_CNT_LSB       8
`define CG_PLL_CNT_MSB       13
`define CG_PLL_MUL_LSB       16
`define CG_PLL_MUL_MSB       26
`define CG_PLL_ONE           29
`define CG_MCK_CSS_LSB       0
`define CG_MCK_CSS_MSB       1
`define CG_MCK_MASTER_PRESCALER_LSB      4
`define CG_MCK_MASTER_PRESCALER_MSB      6
`define CG_MCK_DIV2          12
`define CG_SR_XTS            0
`define CG_SR_LOCK           1
`define CG_SR_MCKRDY         3
`define CG_SR_RCS            17
`define CG_XST_SCALE         3
`define CG_MEAS_PERIODS      5'h10
`define CG_MASTER_PRESCALER_DIV3         3'h7
`define CG_DIV3_LAST         7'h02
`define CG_SYNC_CH           3
`define CG_CH_SLOW           0
`define CG_CH_MAIN           1
`define CG_CH_PLL            2
`endif

// ===== logic/cg_pkg.sv
// Types shared by the clock generator
package cg_pkg;
	typedef enum logic [1:0]
	{
		CG_MEAS_IDLE = 2'b00,
		CG_MEAS_RUN  = 2'b01,
		CG_MEAS_DONE = 2'b10
	} cg_meas_t;
	typedef enum logic [1:0]
	{
		CG_SRC_SLOW = 2'b00,
		CG_SRC_MAIN = 2'b01,
		CG_SRC_PLL  = 2'b10
	} cg_src_t;
endpackage
